// >>> src/isafr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Word 0 bits 7:4 report leading zero count.
// - Word 0 bits 11:8 report bitfield group.
// - Word 0 bits 15:12 report compare-and-branch.
// - Word 0 bits 19:16 cumulative coprocessor level.
// - Word 0 breakpoint 23:20, divide 27:24.
// - Word 1 bits 15:12 report sign/zero extend.
// - Word 1 bits 19:16 report conditional block.
// - Word 1 bits 23:20 report wide immediates.
// - Word 1 bits 27:24 interworking level.
// - Word 2 doubleword 3:0, preload hint 7:4.
// - Word 2 bits 11:8 multi transfer interruption.
// - Word 2 multiply fields 15:12, 19:16, 23:20.
// - Word 2 bits 31:28 reversal level.
// - Word 3 saturate 7:4; bits 3:0 zero.
// - Word 3 supervisor call 11:8, sync 15:12.
// - Word 3 table, low move, no-op fields.
// - Word 4 bits 3:0 unprivileged transfer level.
// - Word 4 bits 7:4 shift level, 2 reserved.
// - Word 4 bits 11:8 writeback mode level.
// - Word 4 barriers 19:16, status move 27:24.
// - Word 4 bits 23:20 qualify sync level.
// - Basic only with immediate or unshifted operand.
// - Reserved fields always read zero.
// - Zero means absent, all ones overflowed.

module isafr_regs (
  input  wire logic        clk_in,           // Core clock, 40 MHz.
  input  wire logic        arst_n_in,        // Asynchronous reset, active low.
  input  wire logic        clk_en_in,        // Freezes all state while low.
  input  wire logic        psel_in,          // APB select.
  input  wire logic        penable_in,       // APB access phase.
  input  wire logic        pwrite_in,        // APB direction, high for write.
  input  wire logic [11:0] paddr_in,         // APB byte address.
  input  wire logic [31:0] pwdata_in,        // APB write data, ignored.
  input  wire logic        op_valid_in,      // Operand query strobe.
  input  wire logic        op_immediate_in,  // Second operand is immediate.
  input  wire logic        op_shifted_in,    // Register operand carries a shift.
  output logic      [31:0] prdata_out,       // APB read data.
  output logic             pready_out,       // APB ready.
  output logic             pslverr_out,      // APB error for unmapped address.
  output logic             op_basic_out,     // Query was a basic instruction.
  output logic             op_shift_dep_out  // Query depends on shift attributes.
);

  // ------------------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------------------

  // Guards a field against a reserved code by forcing it to zero.
  function automatic logic [3:0] isafr_guard(input logic [3:0] lvl,
                                              input logic [3:0] bad);
    isafr_guard = (lvl == bad) ? isafr_pkg::ISAFR_ABSENT : lvl;
  endfunction

  // ------------------------------------------------------------------------
  // Constant attribute words.
  // ------------------------------------------------------------------------

  // Top nibbles of words 0, 1, 3 and 4 and unallocated nibbles are zero so reserved reads are clean.
  logic [31:0] attr0_w;  // Attribute word 0.
  logic [31:0] attr1_w;  // Attribute word 1.
  logic [31:0] attr2_w;  // Attribute word 2.
  logic [31:0] attr3_w;  // Attribute word 3.
  logic [31:0] attr4_w;  // Attribute word 4.
  logic [3:0]  sync_frac_w;  // Qualifier, meaningful only at sync level 1.

  assign attr0_w = {4'h0,
                    isafr_pkg::ISAFR_DIVIDE,
                    isafr_pkg::ISAFR_BREAKPOINT,
                    isafr_pkg::ISAFR_COPROC,
                    isafr_pkg::ISAFR_CMP_BRANCH,
                    isafr_pkg::ISAFR_BITFIELD,
                    isafr_pkg::ISAFR_BIT_COUNT,
                    4'h0};

  assign attr1_w = {4'h0,
                    isafr_pkg::ISAFR_INTERWORK,
                    isafr_pkg::ISAFR_WIDE_IMM,
                    isafr_pkg::ISAFR_COND_BLOCK,
                    isafr_pkg::ISAFR_EXTEND,
                    12'h000};

  assign attr2_w = {isafr_pkg::ISAFR_REVERSAL,
                    4'h0,
                    isafr_pkg::ISAFR_UMULL,
                    isafr_pkg::ISAFR_SMULL,
                    isafr_pkg::ISAFR_MULTIPLY,
                    isafr_pkg::ISAFR_MULTI_INT,
                    isafr_pkg::ISAFR_PRELOAD,
                    isafr_pkg::ISAFR_DWORD_XFER};

  assign attr3_w = {4'h0,
                    isafr_pkg::ISAFR_NOP_HINT,
                    isafr_pkg::ISAFR_LOW_MOVE,
                    isafr_pkg::ISAFR_TABLE_JUMP,
                    isafr_pkg::ISAFR_SYNC,
                    isafr_pkg::ISAFR_SVC,
                    isafr_pkg::ISAFR_PACKED_SAT,
                    isafr_pkg::ISAFR_SAT_SCALAR};

  // The qualifier only means something when the sync field reads 1.
  assign sync_frac_w = (isafr_pkg::ISAFR_SYNC == 4'h1) ?
                       isafr_guard(isafr_guard(isafr_pkg::ISAFR_SYNC_FRAC, 4'h1), 4'h2) :
                       isafr_pkg::ISAFR_ABSENT;

  assign attr4_w = {4'h0,
                    isafr_pkg::ISAFR_STATUS_MOVE,
                    sync_frac_w,
                    isafr_pkg::ISAFR_BARRIER,
                    4'h0,
                    isafr_pkg::ISAFR_WRITEBACK,
                    isafr_guard(isafr_pkg::ISAFR_SHIFTS, 4'h2),
                    isafr_pkg::ISAFR_UNPRIV};

  // ------------------------------------------------------------------------
  // APB slave.
  // ------------------------------------------------------------------------

  logic        access_w;  // Access phase of a transfer.
  logic [31:0] rd_d;      // Read data mux.
  logic        hit_d;     // Address is mapped.
  logic [31:0] prdata_q;  // Registered read data.
  logic        pready_q;  // Registered ready.
  logic        perr_q;    // Registered error.
  logic [1:0]  dec_q;     // Operand class status.

  assign access_w = psel_in && penable_in && !pready_q;

  // Read mux; unmapped addresses read zero and flag an error.
  always_comb begin
    hit_d = 1'b1;
    case (paddr_in)
      isafr_pkg::ISAFR_ADDR_ATTR0: rd_d = attr0_w;
      isafr_pkg::ISAFR_ADDR_ATTR1: rd_d = attr1_w;
      isafr_pkg::ISAFR_ADDR_ATTR2: rd_d = attr2_w;
      isafr_pkg::ISAFR_ADDR_ATTR3: rd_d = attr3_w;
      isafr_pkg::ISAFR_ADDR_ATTR4: rd_d = attr4_w;
      isafr_pkg::ISAFR_ADDR_DEC:   rd_d = {30'h0000_0000, dec_q};
      default: begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b0;
      end
    endcase
  end

  // One wait state: ready rises in the cycle after the access phase starts.
  // Writes are accepted but change nothing: the attribute words are constants and the status word is not written.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
    end else if (clk_en_in) begin
      pready_q <= access_w;
      perr_q   <= access_w && !hit_d;
      prdata_q <= (access_w && !pwrite_in) ? rd_d : 32'h0000_0000;
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = perr_q;

  // ------------------------------------------------------------------------
  // Operand classifier.
  // ------------------------------------------------------------------------

  // Synchronised copies of the query inputs; first stage read only by second.
  logic [2:0] op_s1_q;  // First synchroniser stage.
  logic [2:0] op_s2_q;  // Second synchroniser stage.
  logic       basic_q;  // Basic result.
  logic       shdep_q;  // Shift dependency result.

  // Two flops for inputs from outside the clock domain.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_s1_q <= 3'h0;
      op_s2_q <= 3'h0;
    end else if (clk_en_in) begin
      op_s1_q <= {op_valid_in, op_immediate_in, op_shifted_in};
      op_s2_q <= op_s1_q;
    end
  end

  // Basic only if immediate or an unshifted register; otherwise shift-dependent.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      basic_q <= 1'b0;
      shdep_q <= 1'b0;
      dec_q   <= 2'h0;
    end else if (clk_en_in) begin
      basic_q <= op_s2_q[2] && (op_s2_q[1] || !op_s2_q[0]);
      shdep_q <= op_s2_q[2] && !op_s2_q[1] && op_s2_q[0];
      if (op_s2_q[2]) begin
        dec_q[isafr_pkg::ISAFR_DEC_BASIC_BIT] <= op_s2_q[1] || !op_s2_q[0];
        dec_q[isafr_pkg::ISAFR_DEC_SHIFT_BIT] <= !op_s2_q[1] && op_s2_q[0];
      end
    end
  end

  assign op_basic_out     = basic_q;
  assign op_shift_dep_out = shdep_q;

  // ------------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------------

  a_ready_one_cycle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    pready_q |=> !pready_q) else $error("ready held too long");

  a_ready_follows_access: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (clk_en_in && psel_in && penable_in && !pready_q) |=> pready_q)
    else $error("ready missing");

  a_attr0_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (clk_en_in && access_w && !pwrite_in && paddr_in == isafr_pkg::ISAFR_ADDR_ATTR0)
    |=> prdata_q[31:28] == 4'h0 && prdata_q[3:0] == 4'h0)
    else $error("word 0 reserved bits");

  a_attr3_sat_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (clk_en_in && access_w && !pwrite_in && paddr_in == isafr_pkg::ISAFR_ADDR_ATTR3)
    |=> prdata_q[3:0] == 4'h0) else $error("scalar saturate nonzero");

  a_shift_not_two: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    attr4_w[7:4] != 4'h2) else $error("reserved shift level");

  a_frac_legal: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    attr4_w[23:20] == 4'h0 || (attr4_w[23:20] == 4'h3 && attr3_w[15:12] == 4'h1))
    else $error("bad sync qualifier");

  a_write_no_data: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (clk_en_in && access_w && pwrite_in) |=> prdata_q == 32'h0000_0000)
    else $error("write returned data");

  a_unmapped_err: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (clk_en_in && access_w && !hit_d) |=> perr_q && prdata_q == 32'h0000_0000)
    else $error("unmapped not flagged");

  a_class_exclusive: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !(basic_q && shdep_q)) else $error("both classes set");

  a_imm_is_basic: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (clk_en_in && op_s2_q[2] && op_s2_q[1]) |=> basic_q)
    else $error("immediate not basic");

endmodule

`default_nettype wire

// >>> src/isafr_pkg.sv
package isafr_pkg;

  // ------------------------------------------------------------------------
  // Register map: byte addresses of the five attribute words and the operand class status on APB.
  // ------------------------------------------------------------------------
  localparam logic [11:0] ISAFR_ADDR_ATTR0 = 12'h000;  // Attribute word 0.
  localparam logic [11:0] ISAFR_ADDR_ATTR1 = 12'h004;  // Attribute word 1.
  localparam logic [11:0] ISAFR_ADDR_ATTR2 = 12'h008;  // Attribute word 2.
  localparam logic [11:0] ISAFR_ADDR_ATTR3 = 12'h00c;  // Attribute word 3.
  localparam logic [11:0] ISAFR_ADDR_ATTR4 = 12'h010;  // Attribute word 4.
  localparam logic [11:0] ISAFR_ADDR_DEC   = 12'h014;  // Operand class status.

  // ------------------------------------------------------------------------
  // Field levels chosen for this implementation, one nibble each.
  // ------------------------------------------------------------------------
  localparam logic [3:0] ISAFR_BIT_COUNT    = 4'h1;  // Leading zero count present.
  localparam logic [3:0] ISAFR_BITFIELD     = 4'h1;  // Bitfield group present.
  localparam logic [3:0] ISAFR_CMP_BRANCH   = 4'h1;  // Compare and branch present.
  localparam logic [3:0] ISAFR_COPROC       = 4'h0;  // No generic coprocessor.
  localparam logic [3:0] ISAFR_BREAKPOINT   = 4'h1;  // Breakpoint present.
  localparam logic [3:0] ISAFR_DIVIDE       = 4'h1;  // Hardware divide present.
  localparam logic [3:0] ISAFR_EXTEND       = 4'h1;  // Sign/zero extend present.
  localparam logic [3:0] ISAFR_COND_BLOCK   = 4'h1;  // Conditional block present.
  localparam logic [3:0] ISAFR_WIDE_IMM     = 4'h1;  // Wide immediates present.
  localparam logic [3:0] ISAFR_INTERWORK    = 4'h2;  // Full interworking.
  localparam logic [3:0] ISAFR_DWORD_XFER   = 4'h1;  // Doubleword pair present.
  localparam logic [3:0] ISAFR_PRELOAD      = 4'h3;  // Data and instruction preload.
  localparam logic [3:0] ISAFR_MULTI_INT    = 4'h2;  // Continuable multi transfers.
  localparam logic [3:0] ISAFR_MULTIPLY     = 4'h2;  // Multiply-subtract level.
  localparam logic [3:0] ISAFR_SMULL        = 4'h1;  // Signed long multiply.
  localparam logic [3:0] ISAFR_UMULL        = 4'h1;  // Unsigned long multiply.
  localparam logic [3:0] ISAFR_REVERSAL     = 4'h2;  // Byte and bit reverse.
  localparam logic [3:0] ISAFR_SAT_SCALAR   = 4'h0;  // Not applicable here.
  localparam logic [3:0] ISAFR_PACKED_SAT   = 4'h1;  // Saturate and sticky flag.
  localparam logic [3:0] ISAFR_SVC          = 4'h1;  // Supervisor call.
  localparam logic [3:0] ISAFR_SYNC         = 4'h1;  // Word exclusives.
  localparam logic [3:0] ISAFR_TABLE_JUMP   = 4'h1;  // Table branch.
  localparam logic [3:0] ISAFR_LOW_MOVE     = 4'h1;  // Low to low move.
  localparam logic [3:0] ISAFR_NOP_HINT     = 4'h1;  // True no-operation.
  localparam logic [3:0] ISAFR_UNPRIV       = 4'h2;  // All unprivileged forms.
  localparam logic [3:0] ISAFR_SHIFTS       = 4'h3;  // Constant shifts.
  localparam logic [3:0] ISAFR_WRITEBACK    = 4'h1;  // All writeback modes.
  localparam logic [3:0] ISAFR_BARRIER      = 4'h1;  // Barriers present.
  localparam logic [3:0] ISAFR_SYNC_FRAC    = 4'h3;  // Clear-exclusive and narrow.
  localparam logic [3:0] ISAFR_STATUS_MOVE  = 4'h1;  // State change and status move.
  localparam logic [3:0] ISAFR_ABSENT       = 4'h0;  // All zeros: feature absent.
  localparam logic [3:0] ISAFR_OVERFLOW     = 4'hf;  // All ones: defined elsewhere.

  // ------------------------------------------------------------------------
  // Operand class status bits.
  // ------------------------------------------------------------------------
  localparam int ISAFR_DEC_BASIC_BIT = 0;  // Last query classified as basic.
  localparam int ISAFR_DEC_SHIFT_BIT = 1;  // Needs the shift attribute.

endpackage

// >>> verif/isafr_tb.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;

  // ------------------------------------------------------------------------
  // Stimulus, expectation queues and counters.
  // ------------------------------------------------------------------------
  logic        clk_in     = 1'b0;   // Core clock, 25 ns period.
  logic        arst_n_in  = 1'b0;   // Reset, held low at start.
  logic        psel       = 1'b0;   // APB select.
  logic        penable    = 1'b0;   // APB access phase.
  logic        pwrite     = 1'b0;   // APB direction.
  logic [11:0] paddr      = 12'h000; // APB address.
  logic [31:0] pwdata     = 32'h0;  // APB write data.
  logic        op_valid   = 1'b0;   // Query strobe.
  logic        op_imm     = 1'b0;   // Query: immediate operand.
  logic        op_sh      = 1'b0;   // Query: shifted register.
  logic [31:0] prdata;              // Read data from the block.
  logic        pready;              // Ready from the block.
  logic        pslverr;             // Error from the block.
  logic        op_basic;            // Basic class result.
  logic        op_dep;              // Shift-dependent result.
  logic [31:0] exp_w [5];           // Expected attribute words.
  logic [33:0] apb_q [$];           // Check flag, error, data.
  logic [1:0]  op_q  [$];           // Shift-dependent, basic.
  int          errors      = 0;     // Mismatches seen.
  int          comparisons = 0;     // Comparisons made.

  always #12.5 clk_in = ~clk_in;

  // Clock enable is held high; freezing is left out to keep the run short.
  isafr_regs uut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .op_valid_in(op_valid),
    .op_immediate_in(op_imm), .op_shifted_in(op_sh), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .op_basic_out(op_basic),
    .op_shift_dep_out(op_dep)
  );

  // ------------------------------------------------------------------------
  // Closing report and compare tasks.
  // ------------------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_apb(input logic [33:0] e);
    comparisons++;
    if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
      errors++;
      $display("[ERR] %0t apb got %h/%b want %h/%b", $time, prdata, pslverr, e[31:0], e[32]);
    end
  endtask

  task automatic check_op(input logic [1:0] e);
    comparisons++;
    if ({op_dep, op_basic} !== e) begin
      errors++;
      $display("[ERR] %0t class got %b%b want %b", $time, op_dep, op_basic, e);
    end
  endtask

  // The monitor takes the oldest note whenever a result appears.
  always @(posedge clk_in) begin
    if (pready === 1'b1) begin
      if (apb_q.size() == 0) begin
        errors++;
        $display("[ERR] %0t unexpected ready", $time);
      end else begin
        check_apb(apb_q.pop_front());
      end
    end
    if (op_basic === 1'b1 || op_dep === 1'b1) begin
      if (op_q.size() == 0) begin
        errors++;
        $display("[ERR] %0t unexpected class result", $time);
      end else begin
        check_op(op_q.pop_front());
      end
    end
  end

  // One APB transfer; waits for ready under a bound, never a fixed count.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee, input logic ck);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    apb_q.push_back({ck, ee, ed});
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("[ERR] %0t ready never came", $time);
      results();
    end
  endtask

  // Bound on the whole run, so a hang still reaches the verdict.
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    $display("[ERR] %0t run limit reached", $time);
    results();
  end

  // ------------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------------
  initial begin
    logic b;
    logic s;
    b = 1'b0;
    s = 1'b0;
    // Words are assembled field by field from the chosen levels; gaps are zero.
    exp_w[0] = {4'h0, isafr_pkg::ISAFR_DIVIDE, isafr_pkg::ISAFR_BREAKPOINT,
                isafr_pkg::ISAFR_COPROC, isafr_pkg::ISAFR_CMP_BRANCH,
                isafr_pkg::ISAFR_BITFIELD, isafr_pkg::ISAFR_BIT_COUNT, 4'h0};
    exp_w[1] = {4'h0, isafr_pkg::ISAFR_INTERWORK, isafr_pkg::ISAFR_WIDE_IMM,
                isafr_pkg::ISAFR_COND_BLOCK, isafr_pkg::ISAFR_EXTEND, 12'h000};
    exp_w[2] = {isafr_pkg::ISAFR_REVERSAL, 4'h0, isafr_pkg::ISAFR_UMULL,
                isafr_pkg::ISAFR_SMULL, isafr_pkg::ISAFR_MULTIPLY,
                isafr_pkg::ISAFR_MULTI_INT, isafr_pkg::ISAFR_PRELOAD,
                isafr_pkg::ISAFR_DWORD_XFER};
    exp_w[3] = {4'h0, isafr_pkg::ISAFR_NOP_HINT, isafr_pkg::ISAFR_LOW_MOVE,
                isafr_pkg::ISAFR_TABLE_JUMP, isafr_pkg::ISAFR_SYNC,
                isafr_pkg::ISAFR_SVC, isafr_pkg::ISAFR_PACKED_SAT, 4'h0};
    exp_w[4] = {4'h0, isafr_pkg::ISAFR_STATUS_MOVE, isafr_pkg::ISAFR_SYNC_FRAC,
                isafr_pkg::ISAFR_BARRIER, 4'h0, isafr_pkg::ISAFR_WRITEBACK,
                isafr_pkg::ISAFR_SHIFTS, isafr_pkg::ISAFR_UNPRIV};
    void'($urandom(4));
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, exp_w[i], 1'b0, 1'b1);
    end
    $display("Test attribute words done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'(4 * i), $urandom(), 32'h0, 1'b0, 1'b0);
    end
    for (int i = 4; i >= 0; i--) begin
      apb(1'b0, 12'(4 * i), 32'h0, exp_w[i], 1'b0, 1'b1);
    end
    $display("Test writes ignored done");
    apb(1'b0, 12'h018, 32'h0, 32'h0, 1'b1, 1'b1);
    apb(1'b1, 12'hffc, 32'hffffffff, 32'h0, 1'b1, 1'b0);
    apb(1'b0, 12'hffc, 32'h0, 32'h0, 1'b1, 1'b1);
    $display("Test unmapped addresses done");
    // The four operand forms first, then random ones back to back.
    for (int i = 0; i < 16; i++) begin
      b = (i < 4) ? i[0] : 1'($urandom_range(0, 1));
      s = (i < 4) ? i[1] : 1'($urandom_range(0, 1));
      @(posedge clk_in);
      op_valid <= 1'b1;
      op_imm <= b;
      op_sh <= s;
      op_q.push_back({~b & s, b | ~s});
    end
    @(posedge clk_in);
    op_valid <= 1'b0;
    repeat (6) @(posedge clk_in);
    apb(1'b0, isafr_pkg::ISAFR_ADDR_DEC, 32'h0, {30'h0, ~b & s, b | ~s}, 1'b0, 1'b1);
    $display("Test operand classes done");
    repeat (8) @(posedge clk_in);
    comparisons++;
    if (apb_q.size() != 0 || op_q.size() != 0) begin
      errors++;
      $display("[ERR] %0t results missing", $time);
    end
    results();
  end

endmodule

`default_nettype wire
